// ==== rtl/dl_route_pkg.sv ====
/*
 * Shared constants and carriers for the transmit timeslot router and the
 * receive data link byte collector.
 * Assumes an 8-bit register port and a framer that strobes one link bit
 * per link interval.
 */
package dl_route_pkg;
    localparam logic [7:0] RX_LINK_BYTE_ADDR = 8'h28;
    localparam logic [7:0] RX_LINK_MATCH_A_ADDR = 8'h29;
    localparam logic [7:0] RX_LINK_MATCH_B_ADDR = 8'h2A;
    localparam logic [7:0] TX_SLOT_SELECT_ADDR = 8'h92;
    localparam logic [7:0] TX_BIT_SUPPRESS_ADDR = 8'h93;
    localparam logic [7:0] TX_BLOCK0_ADDR = 8'h94;
    localparam logic [7:0] TX_BLOCK1_ADDR = 8'h95;
    localparam logic [7:0] TX_BLOCK2_ADDR = 8'h96;
    localparam logic [7:0] LINK_STATUS_ADDR = 8'h20;
    localparam logic [7:0] LINK_MASK_ADDR = 8'h21;
    localparam logic [7:0] LINK_CTRL_ADDR = 8'h22;

    localparam int ROUTE_ENABLE_BIT = 7;
    localparam int UNASSIGNED_BIT = 6;
    localparam int SELECT_MODE_BIT = 5;
    localparam int CHAN_MSB = 4;
    localparam int CHAN_LSB = 0;
    localparam int FULL_BIT = 4;
    localparam int MATCH_BIT = 2;
    localparam int DESTUFF_BIT = 0;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [23:0] BLOCK_RESET = 24'h000000;
    localparam int NUM_TIMESLOTS = 24;
    localparam int LINK_BYTE_BITS = 8;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [2:0] ONES_SAT = 3'h6;

    localparam int CLOCK_KHZ = 40000;
    localparam int LINK_BIT_PERIOD_US = 250;
    localparam int LINK_BIT_CYCLES = LINK_BIT_PERIOD_US * CLOCK_KHZ / 1000;
    localparam int LINK_BYTE_CYCLES = LINK_BIT_CYCLES * LINK_BYTE_BITS;

    typedef struct packed {
        logic strobe;
        logic esfMode;
        logic fdlBit;
        logic fsBit;
    } rxLinkIn_t;

    typedef struct packed {
        logic valid;
        logic fdlSlot;
        logic [4:0] timeslot;
        logic [2:0] bitPos;
    } txSlotIn_t;
endpackage

// ==== rtl/dl_route_fdl_rx.sv ====
/*
 * Transmit HDLC timeslot router and legacy receive data link collector
 * with match compare, zero destuffer and active-low interrupt pin.
 * Assumes framer inputs synchronous to core_clk, one register access
 * per strobe, bit position 7 being the timeslot MSB.
 */
module dl_route_fdl_rx (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    input wire logic cpuWr,
    input wire logic cpuRd,
    output logic [7:0] cpuRdData,
    input wire dl_route_pkg::rxLinkIn_t rxLink,
    input wire dl_route_pkg::txSlotIn_t txSlot,
    output logic hdlcTxTake,
    output logic legacyFdlTake,
    output logic intN
);
    logic [7:0] slotSelect_q;
    logic [7:0] bitSuppress_q;
    logic [23:0] blockMask_q;
    logic [7:0] matchA_q;
    logic [7:0] matchB_q;
    logic [7:0] mask_q;
    logic [7:0] ctrl_q;
    logic [7:0] rxByte_q;
    logic [7:0] shift_q;
    logic [2:0] bitCnt_q;
    logic [2:0] ones_q;
    logic fullFlag_q;
    logic matchFlag_q;
    logic linkBit;
    logic dropBit;
    logic takeBit;
    logic byteDone;
    logic [7:0] newByte;
    logic byteMatch;
    logic clrFull;
    logic clrMatch;
    logic slotHit;

    function automatic logic blockedSlot(input logic [23:0] blk, input logic [4:0] ts);
        blockedSlot = (ts < 5'(dl_route_pkg::NUM_TIMESLOTS)) ? blk[ts] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge core_clk) begin
        if (reset) begin
            slotSelect_q <= dl_route_pkg::REG_RESET;
            bitSuppress_q <= dl_route_pkg::REG_RESET;
            blockMask_q <= dl_route_pkg::BLOCK_RESET;
            matchA_q <= dl_route_pkg::REG_RESET;
            matchB_q <= dl_route_pkg::REG_RESET;
            mask_q <= dl_route_pkg::REG_RESET;
            ctrl_q <= dl_route_pkg::REG_RESET;
        end else if (cpuWr) begin
            unique case (cpuAddr)
                dl_route_pkg::TX_SLOT_SELECT_ADDR: slotSelect_q <= cpuWrData;
                dl_route_pkg::TX_BIT_SUPPRESS_ADDR: bitSuppress_q <= cpuWrData;
                dl_route_pkg::TX_BLOCK0_ADDR: blockMask_q[7:0] <= cpuWrData;
                dl_route_pkg::TX_BLOCK1_ADDR: blockMask_q[15:8] <= cpuWrData;
                dl_route_pkg::TX_BLOCK2_ADDR: blockMask_q[23:16] <= cpuWrData;
                dl_route_pkg::RX_LINK_MATCH_A_ADDR: matchA_q <= cpuWrData;
                dl_route_pkg::RX_LINK_MATCH_B_ADDR: matchB_q <= cpuWrData;
                dl_route_pkg::LINK_MASK_ADDR: mask_q <= cpuWrData;
                dl_route_pkg::LINK_CTRL_ADDR: ctrl_q <= cpuWrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpuRdData <= dl_route_pkg::REG_RESET;
        end else if (cpuRd) begin
            unique case (cpuAddr)
                dl_route_pkg::RX_LINK_BYTE_ADDR: cpuRdData <= rxByte_q;
                dl_route_pkg::RX_LINK_MATCH_A_ADDR: cpuRdData <= matchA_q;
                dl_route_pkg::RX_LINK_MATCH_B_ADDR: cpuRdData <= matchB_q;
                dl_route_pkg::TX_SLOT_SELECT_ADDR: cpuRdData <= slotSelect_q;
                dl_route_pkg::TX_BIT_SUPPRESS_ADDR: cpuRdData <= bitSuppress_q;
                dl_route_pkg::TX_BLOCK0_ADDR: cpuRdData <= blockMask_q[7:0];
                dl_route_pkg::TX_BLOCK1_ADDR: cpuRdData <= blockMask_q[15:8];
                dl_route_pkg::TX_BLOCK2_ADDR: cpuRdData <= blockMask_q[23:16];
                dl_route_pkg::LINK_STATUS_ADDR: begin
                    cpuRdData <= 8'h00;
                    cpuRdData[dl_route_pkg::FULL_BIT] <= fullFlag_q;
                    cpuRdData[dl_route_pkg::MATCH_BIT] <= matchFlag_q;
                end
                dl_route_pkg::LINK_MASK_ADDR: cpuRdData <= mask_q;
                dl_route_pkg::LINK_CTRL_ADDR: cpuRdData <= ctrl_q;
                default: cpuRdData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit timeslot routing
    always_comb begin
        if (slotSelect_q[dl_route_pkg::SELECT_MODE_BIT]) begin
            slotHit = blockedSlot(blockMask_q, txSlot.timeslot);
        end else begin
            slotHit = txSlot.timeslot == slotSelect_q[dl_route_pkg::CHAN_MSB:dl_route_pkg::CHAN_LSB];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hdlcTxTake <= 1'b0;
            legacyFdlTake <= 1'b0;
        end else if (!txSlot.valid) begin
            hdlcTxTake <= 1'b0;
            legacyFdlTake <= 1'b0;
        end else if (slotSelect_q[dl_route_pkg::ROUTE_ENABLE_BIT]) begin
            hdlcTxTake <= slotHit && !bitSuppress_q[txSlot.bitPos];
            legacyFdlTake <= txSlot.fdlSlot;
        end else begin
            hdlcTxTake <= txSlot.fdlSlot;
            legacyFdlTake <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive data link collector, independent of the HDLC receiver
    assign linkBit = rxLink.esfMode ? rxLink.fdlBit : rxLink.fsBit;
    assign dropBit = ctrl_q[dl_route_pkg::DESTUFF_BIT] && !linkBit && ones_q == dl_route_pkg::STUFF_ONES;
    assign takeBit = rxLink.strobe && !dropBit;
    assign byteDone = takeBit && bitCnt_q == 3'(dl_route_pkg::LINK_BYTE_BITS - 1);
    assign newByte = {linkBit, shift_q[7:1]};
    assign byteMatch = newByte == matchA_q || newByte == matchB_q;
    assign clrFull = cpuWr && cpuAddr == dl_route_pkg::LINK_STATUS_ADDR && cpuWrData[dl_route_pkg::FULL_BIT];
    assign clrMatch = cpuWr && cpuAddr == dl_route_pkg::LINK_STATUS_ADDR && cpuWrData[dl_route_pkg::MATCH_BIT];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ones_q <= 3'h0;
        end else if (rxLink.strobe) begin
            if (!linkBit) begin
                ones_q <= 3'h0;
            end else if (ones_q != dl_route_pkg::ONES_SAT) begin
                ones_q <= ones_q + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_q <= 8'h00;
            bitCnt_q <= 3'h0;
        end else if (takeBit) begin
            shift_q <= newByte;
            bitCnt_q <= bitCnt_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxByte_q <= 8'h00;
        end else if (byteDone) begin
            rxByte_q <= newByte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fullFlag_q <= 1'b0;
            matchFlag_q <= 1'b0;
        end else begin
            fullFlag_q <= byteDone || (fullFlag_q && !clrFull);
            matchFlag_q <= (byteDone && byteMatch) || (matchFlag_q && !clrMatch);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            intN <= 1'b1;
        end else begin
            intN <= !((fullFlag_q && mask_q[dl_route_pkg::FULL_BIT]) ||
                      (matchFlag_q && mask_q[dl_route_pkg::MATCH_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence byteEnds;
        byteDone;
    endsequence

    sequence flagRaised;
        ##1 fullFlag_q;
    endsequence

    chk_full_on_byte: assert property (byteEnds |-> flagRaised)
        else $error("full flag not raised after byte");
    chk_irq_full_pin: assert property (fullFlag_q && mask_q[dl_route_pkg::FULL_BIT] |=> !intN)
        else $error("interrupt pin not low on full");
    chk_match_set: assert property (byteDone && newByte == matchB_q |=> matchFlag_q)
        else $error("match flag not raised");
    chk_no_false_match: assert property (byteDone && !byteMatch && !matchFlag_q |=> !matchFlag_q)
        else $error("match flag raised without match");
    chk_destuff_drop: assert property (rxLink.strobe && dropBit |=> $stable(bitCnt_q) && $stable(shift_q))
        else $error("stuffed zero not removed");
    chk_keep_zero: assert property (rxLink.strobe && !linkBit && ones_q == dl_route_pkg::ONES_SAT
                                    |=> bitCnt_q == $past(bitCnt_q) + 3'h1)
        else $error("zero after six ones removed");
    chk_lsb_order: assert property (byteDone |=> rxByte_q[7] == $past(linkBit)
                                    && rxByte_q[6:0] == $past(shift_q[7:1]))
        else $error("received byte order wrong");
    chk_fdl_route: assert property (txSlot.valid && !slotSelect_q[dl_route_pkg::ROUTE_ENABLE_BIT]
                                    |=> hdlcTxTake == $past(txSlot.fdlSlot) && !legacyFdlTake)
        else $error("controller not on data link");
    chk_suppress_bit: assert property (txSlot.valid && slotSelect_q[dl_route_pkg::ROUTE_ENABLE_BIT]
                                       && bitSuppress_q[txSlot.bitPos] |=> !hdlcTxTake)
        else $error("suppressed bit used");
    chk_single_chan: assert property (txSlot.valid && slotSelect_q[7:5] == 3'h4 && !bitSuppress_q[txSlot.bitPos]
                                      && txSlot.timeslot == slotSelect_q[4:0] |=> hdlcTxTake)
        else $error("selected channel not used");
    chk_flag_hold: assert property (fullFlag_q && !clrFull |=> fullFlag_q)
        else $error("full flag dropped");
endmodule

// ==== testbench/link_framer_model.sv ====
/*
 * Framer side model: serial receive link bits and transmit bit times.
 * Assumes core_clk from the bench; drives 1 ns after the rising edge.
 */
module link_framer_model (
    input wire logic core_clk,
    output dl_route_pkg::rxLinkIn_t rxLink,
    output dl_route_pkg::txSlotIn_t txSlot
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxLink = '0;
        txSlot = '0;
    end
    //////////////////////////////////////////////////////////////////////
    // one link bit; the unused position carries the inverse
    task automatic linkBit(input logic esf, input logic b);
        @(posedge core_clk) #1;
        rxLink = {1'b1, esf, esf ? b : ~b, esf ? ~b : b};
        @(posedge core_clk) #1;
        rxLink.strobe = 1'b0;
        rxLink.fdlBit = ~rxLink.fdlBit;
        rxLink.fsBit = ~rxLink.fsBit;
    endtask
    task automatic slotBit(input logic fdl, input logic [4:0] ts, input logic [2:0] pos);
        @(posedge core_clk) #1;
        txSlot = {1'b1, fdl, ts, pos};
        @(posedge core_clk) #1;
        txSlot.valid = 1'b0;
    endtask
endmodule

// ==== testbench/dl_route_fdl_rx_tb.sv ====
/*
 * Bench for the timeslot router and the receive link byte collector.
 * Assumes the framer model drives the link and slot inputs.
 */
module dl_route_fdl_rx_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] cpuAddr = 8'h00;
    logic [7:0] cpuWrData = 8'h00;
    logic cpuWr = 1'b0;
    logic cpuRd = 1'b0;
    logic [7:0] cpuRdData;
    logic hdlcTxTake;
    logic legacyFdlTake;
    logic intN;
    dl_route_pkg::rxLinkIn_t rxLink;
    dl_route_pkg::txSlotIn_t txSlot;
    int nMismatch = 0;
    int cmpCount = 0;
    always #12.5 core_clk = ~core_clk;
    dl_route_fdl_rx DUT (.core_clk(core_clk), .reset(reset), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
        .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdData(cpuRdData), .rxLink(rxLink), .txSlot(txSlot),
        .hdlcTxTake(hdlcTxTake), .legacyFdlTake(legacyFdlTake), .intN(intN));
    link_framer_model framer (.core_clk(core_clk), .rxLink(rxLink), .txSlot(txSlot));
    //////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        cpuWr = 1'b1;
        cpuAddr = a;
        cpuWrData = d;
        @(posedge core_clk) #1;
        cpuWr = 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) #1;
        cpuRd = 1'b1;
        cpuAddr = a;
        @(posedge core_clk) #1;
        cpuRd = 1'b0;
        chk8(cpuRdData, exp);
    endtask
    task automatic slotChk(input logic fdl, input logic [4:0] ts, input logic [2:0] pos, input logic h, input logic l);
        framer.slotBit(fdl, ts, pos);
        chk1(hdlcTxTake, h);
        chk1(legacyFdlTake, l);
    endtask
    // bits go out from bit 0 upward
    task automatic sendByte(input logic esf, input logic [15:0] bits, input int n, input logic [7:0] exp);
        for (int i = 0; i < n; i++) framer.linkBit(esf, bits[i]);
        rdChk(8'h28, exp);
    endtask
    // acknowledge both flags and let the pin follow
    task automatic clearFlags;
        regWr(8'h20, 8'h14);
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic closeOut;
        $display("mismatches %0d comparisons %0d", nMismatch, cmpCount);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        #(5000 * 25);
        nMismatch++;
        closeOut();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk1(intN, 1'b1);
        rdChk(8'h92, 8'h00);
        rdChk(8'h50, 8'h00);
        regWr(8'h28, 8'hFF);
        rdChk(8'h28, 8'h00);
        regWr(8'h92, 8'h85);
        regWr(8'h93, 8'h08);
        rdChk(8'h92, 8'h85);
        for (int p = 0; p < 8; p++) slotChk(1'b0, 5'h05, p[2:0], p != 3, 1'b0);
        slotChk(1'b0, 5'h15, 3'h0, 1'b0, 1'b0);
        slotChk(1'b1, 5'h00, 3'h0, 1'b0, 1'b1);
        regWr(8'h92, 8'hA0);
        regWr(8'h95, 8'h01);
        regWr(8'h93, 8'h00);
        slotChk(1'b0, 5'h08, 3'h7, 1'b1, 1'b0);
        slotChk(1'b0, 5'h00, 3'h7, 1'b0, 1'b0);
        regWr(8'h92, 8'h00);
        slotChk(1'b1, 5'h00, 3'h0, 1'b1, 1'b0);
        slotChk(1'b0, 5'h08, 3'h0, 1'b0, 1'b0);
        regWr(8'h29, 8'hA5);
        regWr(8'h2A, 8'h3C);
        rdChk(8'h2A, 8'h3C);
        regWr(8'h21, 8'h14);
        sendByte(1'b1, 16'h00A5, 8, 8'hA5);
        chk1(intN, 1'b0);
        repeat (3) @(posedge core_clk);
        rdChk(8'h20, 8'h14);
        clearFlags();
        chk1(intN, 1'b1);
        rdChk(8'h20, 8'h00);
        sendByte(1'b0, 16'h003C, 8, 8'h3C);
        rdChk(8'h20, 8'h14);
        clearFlags();
        regWr(8'h21, 8'h04);
        sendByte(1'b1, 16'h0002, 8, 8'h02);
        chk1(intN, 1'b1);
        rdChk(8'h20, 8'h10);
        clearFlags();
        regWr(8'h22, 8'h01);
        sendByte(1'b1, 16'h015F, 9, 8'hBF);
        sendByte(1'b1, 16'h009F, 8, 8'h9F);
        closeOut();
    end
endmodule
